/* logic/nvc_ctrl.sv */
// Save/reload controller between config registers and nonvolatile store.
`timescale 1ns/1ps
module nvc_ctrl (
  // Clock, reset and enable.
  input wire logic MCLK,
  input wire logic RST_N,
  input wire logic CE,
  // Decoded register access from the serial port.
  input wire logic REG_WR,
  input wire logic REG_RD,
  input wire logic [11:0] REG_ADDR,
  input wire logic [7:0] REG_WDATA,
  output logic [7:0] REG_RDATA,
  // Pins and configuration.
  input wire logic NVM_SEL_PIN,
  input wire logic STATUS_SEL,
  output logic STATUS_PIN,
  output logic SOFT_RST,
  // Buffer segment, combinational read.
  output logic [7:0] SEG_ADDR,
  input wire logic [7:0] SEG_DATA,
  // Configuration register bank.
  output logic [15:0] CFG_RADDR,
  input wire logic [7:0] CFG_RDATA,
  output logic CFG_WE,
  output logic [15:0] CFG_WADDR,
  output logic [7:0] CFG_WDATA,
  output logic CFG_UPD,
  // Nonvolatile store.
  output logic [15:0] NVM_ADDR,
  input wire logic [7:0] NVM_RDATA,
  output logic NVM_WE,
  output logic [7:0] NVM_WDATA,
  input wire logic NVM_BUSY,
  input wire logic NVM_ERR
);

  // ------------------------------------------------------------------
  // State
  // ------------------------------------------------------------------
  typedef struct packed {
    nvc_pkg::nvc_state_t st; // Engine state.
    logic sel_s1; // Select pin, first sync stage.
    logic sel_s2; // Select pin, synchronised.
    logic guard; // Store write enable.
    logic soft_bit; // Soft reload pending.
    logic save_bit; // Save pending.
    logic busy; // Transfer in progress.
    logic err; // Error of the last transfer.
    logic err_acc; // Error gathered in this transfer.
    logic mode_save; // Direction: 1 save, 0 reload.
    logic [7:0] seg_ptr; // Buffer segment index.
    logic [7:0] addr_hi; // Start address upper byte.
    logic [7:0] cnt_prod; // Bytes still to read.
    logic [7:0] cnt_cons; // Bytes still to write.
    logic [15:0] cfg_raddr; // Register read pointer.
    logic [15:0] cfg_wptr; // Register write pointer.
    logic [15:0] cfg_waddr; // Register write address.
    logic [7:0] cfg_wdata; // Register write data.
    logic cfg_we; // Register write strobe.
    logic cfg_upd; // Register update strobe.
    logic [15:0] nvm_addr; // Store pointer.
    logic [7:0] nvm_wdata; // Store write data.
    logic nvm_we; // Store write strobe.
    logic soft_rst; // Soft reset pulse.
    logic status_pin; // Status pin level.
    logic [7:0] rdata; // Register read data.
    logic [6:0] gap; // Cycles left of the transfer gap.
  } nvc_st_t;

  nvc_st_t s_q;
  nvc_st_t s_d;
  logic fin; // The transfer ends this cycle.
  logic in_valid; // A source byte is offered.
  logic in_ready; // The FIFO has room.
  logic out_valid; // A byte waits in the FIFO.
  logic out_ready; // The sink takes a byte.
  logic [7:0] in_data; // Source byte.
  logic [7:0] out_data; // Byte leaving the FIFO.
  logic push;
  logic pop;

  // ------------------------------------------------------------------
  // Data path through the FIFO
  // ------------------------------------------------------------------
  // Reads stop while the FIFO is full, so a slow store stalls the source.
  assign in_valid = (s_q.st == nvc_pkg::S_MOVE) && (s_q.cnt_prod != '0);
  assign in_data = s_q.mode_save ? CFG_RDATA : NVM_RDATA;
  assign push = in_valid && in_ready;
  // The store takes one byte per two cycles at most, and none when busy.
  assign out_ready = (s_q.st == nvc_pkg::S_MOVE) && (s_q.cnt_cons != '0) &&
                     (!s_q.mode_save || (!s_q.nvm_we && !NVM_BUSY));
  assign pop = out_valid && out_ready;

  nvc_fifo #(
    .W(nvc_pkg::FIFO_WIDTH),
    .D(nvc_pkg::FIFO_DEPTH)
  ) u_fifo (
    .clk(MCLK),
    .rst_n(RST_N),
    .ce(CE),
    .in_valid(in_valid),
    .in_ready(in_ready),
    .in_data(in_data),
    .out_valid(out_valid),
    .out_ready(out_ready),
    .out_data(out_data)
  );

  // ------------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------------
  always_comb begin
    fin = 1'b0;
    s_d = s_q;
    // Strobes last one cycle.
    s_d.cfg_we = 1'b0;
    s_d.cfg_upd = 1'b0;
    s_d.nvm_we = 1'b0;
    s_d.soft_rst = 1'b0;
    // The first stage feeds only the second.
    s_d.sel_s1 = NVM_SEL_PIN;
    s_d.sel_s2 = s_q.sel_s1;
    // Busy shown on the pin only when selected.
    s_d.status_pin = STATUS_SEL && s_q.busy;
    if (s_q.gap != '0) begin
      s_d.gap = s_q.gap - 7'h1;
    end
    // A byte read from the source advances its pointer.
    if (push) begin
      s_d.cnt_prod = s_q.cnt_prod - 8'h1;
      if (s_q.mode_save) begin
        s_d.cfg_raddr = s_q.cfg_raddr + 16'h1;
      end else begin
        s_d.nvm_addr = s_q.nvm_addr + 16'h1;
        if (NVM_ERR) begin
          s_d.err_acc = 1'b1;
        end
      end
    end
    // A byte leaving the FIFO becomes one write strobe, or an error in a save with the guard off.
    if (pop) begin
      s_d.cnt_cons = s_q.cnt_cons - 8'h1;
      if (s_q.mode_save) begin
        s_d.nvm_we = s_q.guard;
        s_d.nvm_wdata = out_data;
        if (!s_q.guard) begin
          s_d.err_acc = 1'b1;
        end
      end else begin
        s_d.cfg_we = 1'b1;
        s_d.cfg_waddr = s_q.cfg_wptr;
        s_d.cfg_wdata = out_data;
        s_d.cfg_wptr = s_q.cfg_wptr + 16'h1;
      end
    end
    // The store address moves on after its write, with the check result.
    if (s_q.nvm_we) begin
      s_d.nvm_addr = s_q.nvm_addr + 16'h1;
      if (NVM_ERR) begin
        s_d.err_acc = 1'b1;
      end
    end
    case (s_q.st)
      nvc_pkg::S_IDLE: begin
        // A new transfer waits out the gap after the last one.
        if (s_q.gap == '0 && (s_q.soft_bit || s_q.save_bit)) begin
          s_d.busy = 1'b1;
          s_d.err_acc = 1'b0;
          s_d.seg_ptr = '0;
          s_d.nvm_addr = '0;
          s_d.mode_save = !s_q.soft_bit;
          s_d.st = s_q.soft_bit ? nvc_pkg::S_RST : nvc_pkg::S_CMD;
        end
      end
      nvc_pkg::S_RST: begin
        // Reset the device before its settings are reloaded.
        s_d.soft_rst = 1'b1;
        s_d.st = nvc_pkg::S_CMD;
      end
      nvc_pkg::S_CMD: begin
        s_d.seg_ptr = s_q.seg_ptr + 8'h1;
        if (!SEG_DATA[nvc_pkg::CMD_OP_BIT]) begin
          // Data transfer: count minus one, then the address.
          s_d.cnt_prod = {1'b0, SEG_DATA[6:0]} + 8'h1;
          s_d.cnt_cons = {1'b0, SEG_DATA[6:0]} + 8'h1;
          s_d.st = nvc_pkg::S_AHI;
        end else if (SEG_DATA == nvc_pkg::OP_EOD) begin
          fin = 1'b1;
        end else if (SEG_DATA == nvc_pkg::OP_IOUPD && !s_q.mode_save) begin
          s_d.cfg_upd = 1'b1;
        end
        // Running off the segment without an end marker is an error.
        if (s_q.seg_ptr == nvc_pkg::SEG_LAST &&
            SEG_DATA != nvc_pkg::OP_EOD) begin
          s_d.err_acc = 1'b1;
          fin = 1'b1;
        end
      end
      nvc_pkg::S_AHI: begin
        // Upper address byte comes first.
        s_d.addr_hi = SEG_DATA;
        s_d.seg_ptr = s_q.seg_ptr + 8'h1;
        s_d.st = nvc_pkg::S_ALO;
      end
      nvc_pkg::S_ALO: begin
        s_d.seg_ptr = s_q.seg_ptr + 8'h1;
        s_d.cfg_raddr = {s_q.addr_hi, SEG_DATA};
        s_d.cfg_wptr = {s_q.addr_hi, SEG_DATA};
        s_d.st = nvc_pkg::S_MOVE;
      end
      nvc_pkg::S_MOVE: begin
        // Done once every byte is written and the last strobe is out.
        if (s_q.cnt_cons == '0 && !s_q.nvm_we) begin
          s_d.st = nvc_pkg::S_CMD;
        end
      end
      default: begin
        s_d.st = nvc_pkg::S_IDLE;
      end
    endcase
    // Completion drops busy, posts the error and clears the trigger.
    if (fin) begin
      s_d.st = nvc_pkg::S_IDLE;
      s_d.busy = 1'b0;
      s_d.err = s_d.err_acc;
      s_d.gap = nvc_pkg::GAP_CYC;
      if (s_q.mode_save) begin
        s_d.save_bit = 1'b0;
      end else begin
        s_d.soft_bit = 1'b0;
      end
    end
    // Writes come last so a new trigger wins over the completion clear.
    if (REG_WR && REG_ADDR == nvc_pkg::ADDR_SOFT) begin
      s_d.guard = REG_WDATA[nvc_pkg::BIT_GUARD];
      if (REG_WDATA[nvc_pkg::BIT_SOFT] && !s_q.sel_s2) begin
        s_d.soft_bit = 1'b1;
      end
    end
    if (REG_WR && REG_ADDR == nvc_pkg::ADDR_SAVE &&
        REG_WDATA[nvc_pkg::BIT_SAVE] && s_q.guard) begin
      s_d.save_bit = 1'b1;
    end
    // Read data is held until the next read.
    if (REG_RD) begin
      s_d.rdata = '0;
      case (REG_ADDR)
        nvc_pkg::ADDR_BUSY: s_d.rdata[nvc_pkg::BIT_BUSY] = s_q.busy;
        nvc_pkg::ADDR_ERR: s_d.rdata[nvc_pkg::BIT_ERR] = s_q.err;
        nvc_pkg::ADDR_SOFT: begin
          s_d.rdata[nvc_pkg::BIT_GUARD] = s_q.guard;
          s_d.rdata[nvc_pkg::BIT_SOFT] = s_q.soft_bit;
        end
        nvc_pkg::ADDR_SAVE: s_d.rdata[nvc_pkg::BIT_SAVE] = s_q.save_bit;
        default: s_d.rdata = '0;
      endcase
    end
  end

  // ------------------------------------------------------------------
  // State register
  // ------------------------------------------------------------------
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      s_q <= '0;
      s_q.guard <= nvc_pkg::RST_GUARD;
    end else if (CE) begin
      s_q <= s_d;
    end
  end

  // Every output is a state field.
  assign REG_RDATA = s_q.rdata;
  assign STATUS_PIN = s_q.status_pin;
  assign SOFT_RST = s_q.soft_rst;
  assign SEG_ADDR = s_q.seg_ptr;
  assign CFG_RADDR = s_q.cfg_raddr;
  assign CFG_WE = s_q.cfg_we;
  assign CFG_WADDR = s_q.cfg_waddr;
  assign CFG_WDATA = s_q.cfg_wdata;
  assign CFG_UPD = s_q.cfg_upd;
  assign NVM_ADDR = s_q.nvm_addr;
  assign NVM_WE = s_q.nvm_we;
  assign NVM_WDATA = s_q.nvm_wdata;

  // ------------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------------
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!RST_N);

  a_busy_read: assert property (CE && REG_RD && REG_ADDR ==
    nvc_pkg::ADDR_BUSY |=> REG_RDATA == {7'h0, $past(s_q.busy)})
    else $error("busy flag read wrong");
  a_status_mirror: assert property (CE |=> STATUS_PIN ==
    ($past(STATUS_SEL) && $past(s_q.busy)))
    else $error("status pin does not follow busy");
  a_err_read: assert property (CE && REG_RD && REG_ADDR ==
    nvc_pkg::ADDR_ERR |=> REG_RDATA[0] == $past(s_q.err))
    else $error("error flag read wrong");
  a_soft_pin_block: assert property (CE && s_q.st == nvc_pkg::S_IDLE &&
    !s_q.soft_bit && s_q.sel_s2 |=> !s_q.soft_bit)
    else $error("soft reload armed with select pin high");
  a_guard_blocks: assert property (!s_q.guard && CE |=> !NVM_WE)
    else $error("store written without guard");
  a_save_starts: assert property (CE && s_q.st == nvc_pkg::S_IDLE &&
    s_q.gap == '0 && s_q.save_bit && !s_q.soft_bit
    |=> s_q.busy && s_q.mode_save ##0 s_q.st == nvc_pkg::S_CMD)
    else $error("save did not start");
  a_save_clears: assert property ($fell(s_q.busy) && s_q.mode_save &&
    !($past(REG_WR) && $past(REG_ADDR) == nvc_pkg::ADDR_SAVE)
    |-> !s_q.save_bit)
    else $error("save trigger not cleared");
  a_cmd_data: assert property (CE && s_q.st == nvc_pkg::S_CMD &&
    !SEG_DATA[7] && s_q.seg_ptr != nvc_pkg::SEG_LAST
    |=> s_q.st == nvc_pkg::S_AHI ##1 CE [*2] ##1 s_q.st ==
    nvc_pkg::S_MOVE)
    else $error("data command not followed by address");
  a_eod_ends: assert property (CE && s_q.st == nvc_pkg::S_CMD &&
    SEG_DATA == nvc_pkg::OP_EOD |=> !s_q.busy &&
    s_q.gap == nvc_pkg::GAP_CYC)
    else $error("end marker did not end transfer");
  a_err_posted: assert property ($fell(s_q.busy) |->
    s_q.err == s_q.err_acc)
    else $error("error flag not updated at end");

  c_save_done: cover property ($fell(s_q.busy) && s_q.mode_save);
  c_reload_done: cover property ($fell(s_q.busy) && !s_q.mode_save);
  c_fifo_full: cover property (s_q.st == nvc_pkg::S_MOVE && !in_ready);

endmodule

/* logic/nvc_pkg.sv */
// Constants and types shared by the nonvolatile save/reload controller.
package nvc_pkg;

  // ------------------------------------------------------------------
  // Register offsets and field positions
  // ------------------------------------------------------------------
  localparam logic [11:0] ADDR_BUSY = 12'hb00; // Transfer busy flag.
  localparam logic [11:0] ADDR_ERR = 12'hb01; // Transfer error flag.
  localparam logic [11:0] ADDR_SOFT = 12'hb02; // Reload and write guard.
  localparam logic [11:0] ADDR_SAVE = 12'hb03; // Save trigger.
  localparam int BIT_BUSY = 0; // Busy flag position.
  localparam int BIT_ERR = 0; // Error flag position.
  localparam int BIT_GUARD = 0; // Write-enable guard position.
  localparam int BIT_SOFT = 1; // Soft reload trigger position.
  localparam int BIT_SAVE = 0; // Save trigger position.
  localparam logic RST_GUARD = 1'b0; // Guard is off after reset.

  // ------------------------------------------------------------------
  // Buffer segment command format
  // ------------------------------------------------------------------
  localparam int CMD_OP_BIT = 7; // Set for an operation code.
  localparam logic [7:0] OP_IOUPD = 8'h80; // Register update code.
  localparam logic [7:0] OP_EOD = 8'hff; // End-of-data code.
  localparam logic [7:0] SEG_LAST = 8'hff; // Last segment byte index.

  // ------------------------------------------------------------------
  // Timing
  // ------------------------------------------------------------------
  localparam int CLK_NS = 100; // Clock period in ns.
  localparam int GAP_NS = 10000; // Least gap between transfers, ns.
  localparam int GAP_CYC_I = (GAP_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [6:0] GAP_CYC = 7'(GAP_CYC_I); // Rounded up.

  // ------------------------------------------------------------------
  // Buffering and engine states
  // ------------------------------------------------------------------
  localparam int FIFO_DEPTH = 8; // Words of the transfer FIFO.
  localparam int FIFO_WIDTH = 8; // Bits per FIFO word.

  typedef enum logic [2:0] {
    S_IDLE, S_RST, S_CMD, S_AHI, S_ALO, S_MOVE
  } nvc_state_t;

endpackage

/* logic/nvc_fifo.sv */
// Small synchronous FIFO that carries transfer bytes.
`timescale 1ns/1ps
module nvc_fifo #(
  parameter int W = 8,
  parameter int D = 8
) (
  // Clock, reset and enable.
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  // Filling side.
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  // Draining side.
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);

  localparam int AW = $clog2(D);
  localparam int CW = $clog2(D + 1);

  // ------------------------------------------------------------------
  // State
  // ------------------------------------------------------------------
  typedef struct packed {
    logic [D-1:0][W-1:0] mem; // Storage words.
    logic [AW-1:0] wp; // Write pointer.
    logic [AW-1:0] rp; // Read pointer.
    logic [CW-1:0] cnt; // Words held.
  } nvc_fifo_st_t;

  nvc_fifo_st_t s_q;
  nvc_fifo_st_t s_d;
  logic push;
  logic pop;

  // Full and empty come straight from the word count.
  assign in_ready = (s_q.cnt != CW'(D));
  assign out_valid = (s_q.cnt != '0);
  assign out_data = s_q.mem[s_q.rp];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  // Pointers wrap at the depth, which need not be a power of two.
  always_comb begin
    s_d = s_q;
    if (push) begin
      s_d.mem[s_q.wp] = in_data;
      s_d.wp = (s_q.wp == AW'(D - 1)) ? '0 : s_q.wp + AW'(1);
    end
    if (pop) begin
      s_d.rp = (s_q.rp == AW'(D - 1)) ? '0 : s_q.rp + AW'(1);
    end
    s_d.cnt = s_q.cnt + CW'(push) - CW'(pop);
  end

  // The enable freezes the whole FIFO.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '0;
    end else if (ce) begin
      s_q <= s_d;
    end
  end

endmodule

/* testbench/nvc_far_model.sv */
// Behavioural model of the buffer segment, config bank and store.
`timescale 1ns/1ps
module nvc_far_model (
  // Clock.
  input wire logic clk,
  // Test controls.
  input wire logic slow,
  input wire logic err_inj,
  // Buffer segment.
  input wire logic [7:0] seg_addr,
  output logic [7:0] seg_data,
  // Configuration bank.
  input wire logic [15:0] cfg_raddr,
  output logic [7:0] cfg_rdata,
  input wire logic cfg_we,
  input wire logic [15:0] cfg_waddr,
  input wire logic [7:0] cfg_wdata,
  // Nonvolatile store.
  input wire logic [15:0] nvm_addr,
  output logic [7:0] nvm_rdata,
  input wire logic nvm_we,
  input wire logic [7:0] nvm_wdata,
  output logic nvm_busy,
  output logic nvm_err
);
  // --------------------
  // Storage
  // --------------------
  logic [7:0] seg [256]; // Segment bytes, end marker by default.
  logic [7:0] cfg [256]; // Low page of the config bank.
  logic [7:0] nvm [256]; // Low page of the store.
  logic [2:0] slow_q; // Paces the store's write stalls.

  // Fill the segment with end markers so a stray walk stops at once.
  initial begin
    for (int i = 0; i < 256; i++) begin
      seg[i] = 8'hff;
      cfg[i] = 8'h00;
      nvm[i] = 8'h00;
    end
    slow_q = 3'h0;
  end

  // Reads are combinational, as the controller expects.
  assign seg_data = seg[seg_addr];
  assign cfg_rdata = cfg[cfg_raddr[7:0]];
  assign nvm_rdata = nvm[nvm_addr[7:0]];
  // A slow store stays busy for seven cycles after each write it takes.
  // The FIFO backs up behind it. The controller decides a write one cycle
  // before its strobe, so busy must not rise without a write to cause it.
  assign nvm_busy = slow && (slow_q != 3'h0);
  assign nvm_err = err_inj;

  // Writes land on the sampling edge; a write into a busy store is lost,
  // just as the real part would drop it.
  always @(posedge clk) begin
    if (nvm_we) begin
      slow_q <= 3'h7;
    end else if (slow_q != 3'h0) begin
      slow_q <= slow_q - 3'h1;
    end
    if (cfg_we) begin
      cfg[cfg_waddr[7:0]] <= cfg_wdata;
    end
    if (nvm_we && !nvm_busy) begin
      nvm[nvm_addr[7:0]] <= nvm_wdata;
    end
  end
endmodule

/* testbench/testbench.sv */
// Self-checking bench for the save/reload controller.
`timescale 1ns/1ps
`define CHK(g, e) begin \
  num_checks++; \
  if ((g) !== (e)) begin \
    n_mismatch++; \
    $display("unexpected at %0t: got %h want %h", $time, (g), (e)); \
  end \
end
module testbench;
  // --------------------
  // Stimulus and wires
  // --------------------
  logic MCLK = 1'b0;
  logic RST_N = 1'b0;
  logic CE = 1'b1;
  logic REG_WR = 1'b0;
  logic REG_RD = 1'b0;
  logic [11:0] REG_ADDR = 12'h000;
  logic [7:0] REG_WDATA = 8'h00;
  logic NVM_SEL_PIN = 1'b1; // High keeps soft reload locked out.
  logic STATUS_SEL = 1'b0;
  logic slow = 1'b0;
  logic err_inj = 1'b0;
  logic [7:0] REG_RDATA, SEG_ADDR, SEG_DATA, CFG_RDATA, CFG_WDATA;
  logic [7:0] NVM_RDATA, NVM_WDATA, rd;
  logic [15:0] CFG_RADDR, CFG_WADDR, NVM_ADDR;
  logic STATUS_PIN, SOFT_RST, CFG_WE, CFG_UPD, NVM_WE, NVM_BUSY, NVM_ERR;
  int n_mismatch = 0;
  int num_checks = 0;
  int n_soft = 0; // Soft reset pulses seen.
  int n_upd = 0; // Register update pulses seen.
  int n_stat = 0; // Cycles with the status pin high.

  always #50 MCLK = ~MCLK;

  // Pulses are counted mid-cycle, where they have settled.
  always @(negedge MCLK) begin
    if (SOFT_RST === 1'b1) n_soft++;
    if (CFG_UPD === 1'b1) n_upd++;
    if (STATUS_PIN === 1'b1) n_stat++;
  end

  nvc_ctrl DUT (.MCLK(MCLK), .RST_N(RST_N), .CE(CE), .REG_WR(REG_WR),
    .REG_RD(REG_RD), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA),
    .REG_RDATA(REG_RDATA), .NVM_SEL_PIN(NVM_SEL_PIN),
    .STATUS_SEL(STATUS_SEL), .STATUS_PIN(STATUS_PIN), .SOFT_RST(SOFT_RST),
    .SEG_ADDR(SEG_ADDR), .SEG_DATA(SEG_DATA), .CFG_RADDR(CFG_RADDR),
    .CFG_RDATA(CFG_RDATA), .CFG_WE(CFG_WE), .CFG_WADDR(CFG_WADDR),
    .CFG_WDATA(CFG_WDATA), .CFG_UPD(CFG_UPD), .NVM_ADDR(NVM_ADDR),
    .NVM_RDATA(NVM_RDATA), .NVM_WE(NVM_WE), .NVM_WDATA(NVM_WDATA),
    .NVM_BUSY(NVM_BUSY), .NVM_ERR(NVM_ERR));

  nvc_far_model partner (.clk(MCLK), .slow(slow), .err_inj(err_inj),
    .seg_addr(SEG_ADDR), .seg_data(SEG_DATA), .cfg_raddr(CFG_RADDR),
    .cfg_rdata(CFG_RDATA), .cfg_we(CFG_WE), .cfg_waddr(CFG_WADDR),
    .cfg_wdata(CFG_WDATA), .nvm_addr(NVM_ADDR), .nvm_rdata(NVM_RDATA),
    .nvm_we(NVM_WE), .nvm_wdata(NVM_WDATA), .nvm_busy(NVM_BUSY),
    .nvm_err(NVM_ERR));

  // --------------------
  // Register port tasks
  // --------------------
  // One write, held for exactly the edge that takes it.
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge MCLK);
    #1;
    REG_WR = 1'b1;
    REG_ADDR = a;
    REG_WDATA = d;
    @(posedge MCLK);
    #1;
    REG_WR = 1'b0;
  endtask

  // One read; data is taken a full cycle later, after it has settled.
  task automatic rd_reg(input logic [11:0] a);
    @(posedge MCLK);
    #1;
    REG_RD = 1'b1;
    REG_ADDR = a;
    @(posedge MCLK);
    #1;
    REG_RD = 1'b0;
    @(posedge MCLK);
    #1;
    rd = REG_RDATA;
  endtask

  task automatic close_out();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // Polls the busy flag; the first cycles are skipped because a trigger
  // takes two edges to raise it.
  task automatic wait_idle();
    int i;
    repeat (4) @(posedge MCLK);
    for (i = 0; i < 300; i++) begin
      rd_reg(nvc_pkg::ADDR_BUSY);
      if (rd[0] === 1'b0) break;
    end
    if (i == 300) begin
      n_mismatch++;
      $display("unexpected at %0t: got %h want %h", $time, rd, 8'h00);
      close_out();
    end
  endtask

  // --------------------
  // Scenarios
  // --------------------
  // Reset values, and an unmapped write that must go nowhere.
  task automatic t_reset();
    rd_reg(nvc_pkg::ADDR_BUSY); `CHK(rd, 8'h00)
    rd_reg(nvc_pkg::ADDR_ERR); `CHK(rd, 8'h00)
    wr(12'hb04, 8'hff);
    rd_reg(12'hb04); `CHK(rd, 8'h00)
    rd_reg(nvc_pkg::ADDR_SOFT); `CHK(rd, 8'h00)
    rd_reg(nvc_pkg::ADDR_SAVE); `CHK(rd, 8'h00)
    $display("test reset done");
  endtask

  // A save with the guard off must not start.
  task automatic t_guard();
    wr(nvc_pkg::ADDR_SAVE, 8'h01);
    rd_reg(nvc_pkg::ADDR_SAVE); `CHK(rd, 8'h00)
    rd_reg(nvc_pkg::ADDR_BUSY); `CHK(rd, 8'h00)
    $display("test guard done");
  endtask

  // Ten bytes saved into a store that stalls, so the FIFO fills.
  task automatic t_save();
    partner.seg[0] = 8'h09;
    partner.seg[1] = 8'h00;
    partner.seg[2] = 8'h10;
    partner.seg[3] = 8'hff;
    for (int i = 0; i < 10; i++) partner.cfg[16 + i] = 8'(i * 17 + 1);
    STATUS_SEL = 1'b1;
    slow = 1'b1;
    n_stat = 0;
    wr(nvc_pkg::ADDR_SOFT, 8'h01);
    wr(nvc_pkg::ADDR_SAVE, 8'h01);
    rd_reg(nvc_pkg::ADDR_SAVE); `CHK(rd, 8'h01)
    rd_reg(nvc_pkg::ADDR_BUSY); `CHK(rd, 8'h01)
    wait_idle();
    for (int i = 0; i < 10; i++) begin
      `CHK(partner.nvm[i], 8'(i * 17 + 1))
    end
    rd_reg(nvc_pkg::ADDR_SAVE); `CHK(rd, 8'h00)
    rd_reg(nvc_pkg::ADDR_ERR); `CHK(rd, 8'h00)
    `CHK(n_stat > 20, 1'b1)
    `CHK(STATUS_PIN, 1'b0)
    slow = 1'b0;
    repeat (110) @(posedge MCLK);
    $display("test save done");
  endtask

  // Reload with a register update opcode; e injects a store data error.
  task automatic t_reload(input logic e);
    partner.seg[0] = 8'h01;
    partner.seg[1] = 8'h00;
    partner.seg[2] = 8'h20;
    partner.seg[3] = 8'h80;
    partner.seg[4] = 8'hff;
    partner.nvm[0] = 8'h5a;
    partner.nvm[1] = 8'hc3;
    partner.cfg[32] = 8'h00;
    partner.cfg[33] = 8'h00;
    STATUS_SEL = 1'b0;
    NVM_SEL_PIN = 1'b0;
    err_inj = e;
    n_soft = 0;
    n_upd = 0;
    n_stat = 0;
    repeat (3) @(posedge MCLK);
    wr(nvc_pkg::ADDR_SOFT, 8'h03);
    wait_idle();
    err_inj = 1'b0;
    `CHK(n_soft, 1)
    `CHK(n_upd, 1)
    `CHK(n_stat, 0)
    if (!e) begin
      `CHK(partner.cfg[32], 8'h5a)
      `CHK(partner.cfg[33], 8'hc3)
    end
    rd_reg(nvc_pkg::ADDR_ERR); `CHK(rd, {7'h00, e})
    rd_reg(nvc_pkg::ADDR_SOFT); `CHK(rd, 8'h01)
    repeat (110) @(posedge MCLK);
    $display("test reload done");
  endtask

  // With the select pin high the soft reload bit is refused.
  task automatic t_pin_high();
    NVM_SEL_PIN = 1'b1;
    n_soft = 0;
    repeat (3) @(posedge MCLK);
    wr(nvc_pkg::ADDR_SOFT, 8'h03);
    rd_reg(nvc_pkg::ADDR_SOFT); `CHK(rd, 8'h01)
    rd_reg(nvc_pkg::ADDR_BUSY); `CHK(rd, 8'h00)
    `CHK(n_soft, 0)
    // With the enable low, a write that would drop the guard is lost.
    CE = 1'b0;
    wr(nvc_pkg::ADDR_SOFT, 8'h00);
    CE = 1'b1;
    rd_reg(nvc_pkg::ADDR_SOFT); `CHK(rd, 8'h01)
    $display("test pin high done");
  endtask

  // Main sequence; the error reload is followed by a clean one so the
  // flag must fall again.
  initial begin
    repeat (3) @(posedge MCLK);
    #1;
    RST_N = 1'b1;
    t_reset();
    t_guard();
    t_save();
    t_reload(1'b0);
    t_reload(1'b1);
    t_reload(1'b0);
    t_pin_high();
    close_out();
  end
endmodule
